// ---- hw/bil_pkg.sv ----
// Boot image loader constants, field layout and carrier types
package bil_pkg;
  // Memory map
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam logic [31:0] ROM_BASE = 32'h0010_0000;
  localparam logic [31:0] SRAM_BASE = 32'h0020_0000;
  // Vector area
  localparam logic [4:0] VEC_LAST_BYTE = 5'h1F;
  localparam logic [2:0] SIZE_WORD_IDX = 3'h5;
  localparam logic [3:0] COND_ALWAYS = 4'hE;
  localparam logic [3:0] BRANCH_CODE = 4'hA;
  localparam logic [1:0] LDST_CLASS = 2'h1;
  localparam logic [3:0] PC_REG = 4'hF;
  localparam int COND_LSB = 28;
  localparam int OPC_LSB = 24;
  localparam int CLS_LSB = 26;
  localparam int PRE_BIT = 24;
  localparam int LOAD_BIT = 20;
  localparam int RN_LSB = 16;
  localparam int RD_LSB = 12;
  // Size word fields
  localparam int BLK_LSB = 0;
  localparam int EXP_LSB = 13;
  localparam int PSZ_LSB = 17;
  localparam int BLK_SHIFT = 9;
  // Fallback upload
  localparam logic [7:0] XMODEM_CRC_REQ = 8'h43;
  // USB clock synthesis
  localparam int USB_CLK_HZ = 48_000_000;
  localparam int PLL_POSTDIV = 2;
  localparam int N_XTAL = 29;
  localparam int XTAL_HZ [N_XTAL] = '{
    3000000, 3276800, 3686400, 3840000, 4000000,
    4433619, 4915200, 5000000, 5242880, 6000000,
    6144000, 6400000, 6553600, 7159090, 7372800,
    7864320, 8000000, 9830400, 10000000, 11059200,
    12000000, 12288000, 13560000, 14318180, 14745600,
    16000000, 17734470, 18432000, 20000000};

  typedef enum logic [1:0] {SRC_SPI, SRC_EEPROM, SRC_PAR} bil_src_t;

  typedef enum logic [4:0] {
    ST_OFF, ST_PLL, ST_STACK, ST_OSC, ST_IRQ, ST_VARS, ST_MAIN,
    ST_PROBE_RD, ST_PROBE_WAIT, ST_COPY_RD, ST_COPY_WAIT,
    ST_UP_START, ST_UPLOAD, ST_REMAP, ST_BRANCH, ST_RUN
  } bil_state_t;

  typedef struct packed {
    logic valid;
    bil_src_t src;
    logic [16:0] addr;
  } bil_nvm_req_t;

  typedef struct packed {
    logic ack;
    logic nak;
    logic [7:0] data;
  } bil_nvm_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic done;
  } bil_up_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [7:0] data;
  } bil_sram_wr_t;
endpackage : bil_pkg

// ---- hw/bil_boot_loader.sv ----
// Boot image loader: init, probe, validate, copy, remap, branch
// Behaviour
// RULE1 - Run from reset vector only if boot select high at reset and bus exists.
// RULE2 - Valid image is copied to SRAM, then remap, then branch to zero.
// RULE3 - After reset the boot ROM shows at address zero and ROM base.
// RULE4 - Validation reads the first 32 bytes as eight vector words.
// RULE5 - All words but the sixth must be branch or PC-relative load.
// RULE6 - Each checked word needs condition field 0xE.
// RULE7 - Load accepted with base and destination PC, load and pre-index set.
// RULE8 - Sixth word bits 7..0 count 512-byte blocks to copy.
// RULE9 - Sixth word bits 16..13 give flash page count exponent.
// RULE10 - Sixth word bits 31..17 give flash page size in bytes.
// RULE11 - For EEPROM and parallel memory only the block count is used.
// RULE12 - Init order: PLL, stacks, oscillator, interrupts, variables, main.
// RULE13 - PLL factor picked from measured oscillator; listed crystals known.
// RULE14 - Probe order: serial flash, then EEPROM, then parallel memory.
// RULE15 - No valid image: fall back to USB or debug serial upload.
// RULE16 - Flash geometry comes from the sixth word, not a status read.
// RULE17 - EEPROM found by acknowledge on first read at device address 0.
// RULE18 - Uploaded image is written to SRAM from its base address.
// RULE19 - Serial fallback starts by sending 0x43.
// RULE20 - After remap SRAM sits at zero and ROM at its base.
// RULE21 - Branch word needs bits 27..24 equal to 1010.
// RULE22 - A failing source is dropped and the next one probed.
`timescale 1ns/10ps
module bil_boot_loader (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Straps
  input wire logic boot_mode_select,
  input wire logic ext_bus_present,
  // Oscillator measurement from power_management_block
  input wire logic [31:0] osc_hz,
  input wire logic osc_valid,
  // USB clock synthesis
  output logic [10:0] usb_pll_mul,
  output logic usb_pll_en,
  output logic xtal_known,
  // External memory reads
  output bil_pkg::bil_nvm_req_t nvm_req,
  input wire bil_pkg::bil_nvm_rsp_t nvm_rsp,
  // Serial flash geometry
  output logic [14:0] flash_page_size,
  output logic [15:0] flash_page_count,
  // Internal SRAM writes
  output bil_pkg::bil_sram_wr_t sram_wr,
  // Memory map
  output logic rom_at_zero,
  output logic rom_at_base,
  output logic sram_at_zero,
  // Execution control
  output logic [31:0] fetch_addr,
  output logic branch_pulse,
  output bil_pkg::bil_state_t boot_state,
  // Fallback upload
  output logic dbg_tx_valid,
  output logic [7:0] dbg_tx_data,
  input wire logic dbg_tx_ready,
  output logic usb_port_en,
  input wire bil_pkg::bil_up_t upload
);

  bil_pkg::bil_state_t state_reg;
  bil_pkg::bil_src_t src_reg;
  logic boot_en_reg;
  logic [4:0] byte_idx_reg;
  logic [31:0] word_reg;
  logic [7:0] blocks_reg;
  logic [16:0] copy_cnt_reg;
  logic [31:0] up_cnt_reg;
  logic remap_reg;
  logic [10:0] mul_reg;
  logic known_reg;
  logic pll_en_reg;
  logic [14:0] psz_reg;
  logic [15:0] pcnt_reg;
  logic tx_valid_reg;
  logic usb_en_reg;
  logic branch_reg;
  logic [31:0] fetch_reg;
  bil_pkg::bil_nvm_req_t req_reg;
  bil_pkg::bil_sram_wr_t wr_reg;

  // Crystal match table
  logic [bil_pkg::N_XTAL-1:0] xtal_hit;
  logic [10:0] xtal_mul [bil_pkg::N_XTAL];
  genvar gi;
  generate
    for (gi = 0; gi < bil_pkg::N_XTAL; gi = gi + 1)
    begin : g_xtal
      localparam int MUL = (bil_pkg::USB_CLK_HZ * bil_pkg::PLL_POSTDIV
        + bil_pkg::XTAL_HZ[gi] / 2) / bil_pkg::XTAL_HZ[gi];
      assign xtal_hit[gi] = (osc_hz == 32'(bil_pkg::XTAL_HZ[gi]));
      assign xtal_mul[gi] = 11'(MUL);
    end
  endgenerate

  // RULE13 factor selection
  logic [10:0] mul_sel;
  always_comb
  begin
    mul_sel = 11'h000;
    for (int i = 0; i < bil_pkg::N_XTAL; i++)
      if (xtal_hit[i])
        mul_sel = xtal_mul[i];
  end

  // Vector decode of the word completed by this byte
  wire [31:0] word_w = {nvm_rsp.data, word_reg[31:8]};
  wire [2:0] widx_w = byte_idx_reg[4:2];
  wire word_done = (byte_idx_reg[1:0] == 2'h3);
  // RULE6 condition field
  wire cond_ok = word_w[bil_pkg::COND_LSB +: 4] == bil_pkg::COND_ALWAYS;
  // RULE21 branch form
  wire br_ok = word_w[bil_pkg::OPC_LSB +: 4] == bil_pkg::BRANCH_CODE;
  // RULE7 PC-relative load form
  wire ld_ok = (word_w[bil_pkg::CLS_LSB +: 2] == bil_pkg::LDST_CLASS)
    && word_w[bil_pkg::PRE_BIT] && word_w[bil_pkg::LOAD_BIT]
    && (word_w[bil_pkg::RN_LSB +: 4] == bil_pkg::PC_REG)
    && (word_w[bil_pkg::RD_LSB +: 4] == bil_pkg::PC_REG);
  // RULE5 sixth word exempt
  wire is_size_word = (widx_w == bil_pkg::SIZE_WORD_IDX);
  wire vec_ok = is_size_word || (cond_ok && (br_ok || ld_ok));

  wire probing = (state_reg == bil_pkg::ST_PROBE_WAIT);
  wire got = probing && nvm_rsp.ack;
  // RULE22 source rejection
  wire probe_fail = probing
    && (nvm_rsp.nak || (nvm_rsp.ack && word_done && !vec_ok));
  wire probe_pass = got && word_done && vec_ok
    && (byte_idx_reg == bil_pkg::VEC_LAST_BYTE);
  // RULE8 copy length in bytes
  wire [16:0] copy_total = {blocks_reg, 9'h000};
  wire copy_last = (copy_cnt_reg + 17'h00001 >= copy_total);
  wire last_src = (src_reg == bil_pkg::SRC_PAR);
  wire [31:0] up_addr = bil_pkg::SRAM_BASE + up_cnt_reg;
  wire [31:0] cp_addr = bil_pkg::SRAM_BASE + {15'h0000, copy_cnt_reg};

  // Strap capture while reset is held
  // RULE1 boot enable
  always_ff @(posedge clk)
    if (!resetn)
      boot_en_reg <= boot_mode_select && ext_bus_present;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= bil_pkg::ST_PLL;
      src_reg <= bil_pkg::SRC_SPI;
      byte_idx_reg <= 5'h00;
      word_reg <= 32'h0000_0000;
      blocks_reg <= 8'h00;
      copy_cnt_reg <= 17'h00000;
      up_cnt_reg <= 32'h0000_0000;
      remap_reg <= 1'b0;
      mul_reg <= 11'h000;
      known_reg <= 1'b0;
      pll_en_reg <= 1'b0;
      psz_reg <= 15'h0000;
      pcnt_reg <= 16'h0000;
      tx_valid_reg <= 1'b0;
      usb_en_reg <= 1'b0;
      branch_reg <= 1'b0;
      fetch_reg <= bil_pkg::RESET_VECTOR;
      req_reg <= '0;
      wr_reg <= '0;
    end
    else
    begin
      req_reg.valid <= 1'b0;
      wr_reg.we <= 1'b0;
      branch_reg <= 1'b0;
      case (state_reg)
        // RULE1 held off without strap
        bil_pkg::ST_PLL:
          if (!boot_en_reg)
            state_reg <= bil_pkg::ST_OFF;
          // RULE12 ordered init, RULE13 factor
          else if (osc_valid)
          begin
            mul_reg <= mul_sel;
            pll_en_reg <= |xtal_hit;
            state_reg <= bil_pkg::ST_STACK;
          end
        bil_pkg::ST_STACK: state_reg <= bil_pkg::ST_OSC;
        bil_pkg::ST_OSC:
        begin
          known_reg <= |xtal_hit;
          state_reg <= bil_pkg::ST_IRQ;
        end
        bil_pkg::ST_IRQ: state_reg <= bil_pkg::ST_VARS;
        bil_pkg::ST_VARS: state_reg <= bil_pkg::ST_MAIN;
        bil_pkg::ST_MAIN: state_reg <= bil_pkg::ST_PROBE_RD;
        // RULE4 read vector bytes, RULE17 first read probes ack
        bil_pkg::ST_PROBE_RD:
        begin
          req_reg <= '{valid: 1'b1, src: src_reg,
            addr: {12'h000, byte_idx_reg}};
          state_reg <= bil_pkg::ST_PROBE_WAIT;
        end
        bil_pkg::ST_PROBE_WAIT:
          // RULE14 fixed order, RULE15 fallback
          if (probe_fail)
          begin
            byte_idx_reg <= 5'h00;
            // RULE11 drop rejected geometry
            psz_reg <= 15'h0000;
            pcnt_reg <= 16'h0000;
            if (last_src)
              state_reg <= bil_pkg::ST_UP_START;
            else
            begin
              src_reg <= bil_pkg::bil_src_t'(src_reg + 2'h1);
              state_reg <= bil_pkg::ST_PROBE_RD;
            end
          end
          else if (got)
          begin
            word_reg <= word_w;
            byte_idx_reg <= byte_idx_reg + 5'h01;
            // RULE8 block count, RULE9 RULE10 RULE11 RULE16 geometry
            if (word_done && is_size_word)
            begin
              blocks_reg <= word_w[bil_pkg::BLK_LSB +: 8];
              if (src_reg == bil_pkg::SRC_SPI)
              begin
                psz_reg <= word_w[bil_pkg::PSZ_LSB +: 15];
                pcnt_reg <= 16'h0001 << word_w[bil_pkg::EXP_LSB +: 4];
              end
            end
            if (probe_pass)
            begin
              copy_cnt_reg <= 17'h00000;
              state_reg <= (blocks_reg == 8'h00 && !is_size_word)
                ? bil_pkg::ST_REMAP : bil_pkg::ST_COPY_RD;
            end
            else
              state_reg <= bil_pkg::ST_PROBE_RD;
          end
        // RULE2 copy image into SRAM
        bil_pkg::ST_COPY_RD:
          if (copy_total == 17'h00000)
            state_reg <= bil_pkg::ST_REMAP;
          else
          begin
            req_reg <= '{valid: 1'b1, src: src_reg, addr: copy_cnt_reg};
            state_reg <= bil_pkg::ST_COPY_WAIT;
          end
        bil_pkg::ST_COPY_WAIT:
          if (nvm_rsp.ack)
          begin
            wr_reg <= '{we: 1'b1, addr: cp_addr, data: nvm_rsp.data};
            copy_cnt_reg <= copy_cnt_reg + 17'h00001;
            state_reg <= copy_last ? bil_pkg::ST_REMAP
              : bil_pkg::ST_COPY_RD;
          end
          else if (nvm_rsp.nak)
            state_reg <= bil_pkg::ST_COPY_RD;
        // RULE19 request CRC transfer, RULE15 both ports opened
        bil_pkg::ST_UP_START:
        begin
          tx_valid_reg <= 1'b1;
          usb_en_reg <= 1'b1;
          if (tx_valid_reg && dbg_tx_ready)
          begin
            tx_valid_reg <= 1'b0;
            state_reg <= bil_pkg::ST_UPLOAD;
          end
        end
        // RULE18 upload lands at SRAM base
        bil_pkg::ST_UPLOAD:
          if (upload.valid)
          begin
            wr_reg <= '{we: 1'b1, addr: up_addr, data: upload.data};
            up_cnt_reg <= up_cnt_reg + 32'h0000_0001;
          end
          else if (upload.done)
            state_reg <= bil_pkg::ST_REMAP;
        // RULE2 RULE20 remap then branch
        bil_pkg::ST_REMAP:
        begin
          remap_reg <= 1'b1;
          usb_en_reg <= 1'b0;
          state_reg <= bil_pkg::ST_BRANCH;
        end
        bil_pkg::ST_BRANCH:
        begin
          branch_reg <= 1'b1;
          fetch_reg <= bil_pkg::RESET_VECTOR;
          state_reg <= bil_pkg::ST_RUN;
        end
        bil_pkg::ST_RUN: state_reg <= bil_pkg::ST_RUN;
        bil_pkg::ST_OFF: state_reg <= bil_pkg::ST_OFF;
        default: state_reg <= bil_pkg::ST_OFF;
      endcase
    end
  end

  // RULE3 RULE20 address map
  assign rom_at_zero = !remap_reg;
  assign rom_at_base = 1'b1;
  assign sram_at_zero = remap_reg;
  assign usb_pll_mul = mul_reg;
  assign usb_pll_en = pll_en_reg;
  assign xtal_known = known_reg;
  assign nvm_req = req_reg;
  assign flash_page_size = psz_reg;
  assign flash_page_count = pcnt_reg;
  assign sram_wr = wr_reg;
  assign fetch_addr = fetch_reg;
  assign branch_pulse = branch_reg;
  assign boot_state = state_reg;
  assign dbg_tx_valid = tx_valid_reg;
  assign dbg_tx_data = bil_pkg::XMODEM_CRC_REQ;
  assign usb_port_en = usb_en_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // RULE1 check
  strap_gates_boot_a: // RULE1
    assert property (!boot_en_reg |-> ##1 state_reg == bil_pkg::ST_OFF
      || state_reg == bil_pkg::ST_OFF)
    else $error("boot ran without strap");
  // RULE2 check
  remap_then_branch_a: // RULE2
    assert property (state_reg == bil_pkg::ST_REMAP
      |=> sram_at_zero ##1 branch_pulse && fetch_addr == 32'h0000_0000)
    else $error("remap not followed by branch");
  // RULE3 check
  rom_dual_map_a: // RULE3
    assert property (state_reg != bil_pkg::ST_BRANCH
      && state_reg != bil_pkg::ST_RUN |-> rom_at_zero && rom_at_base)
    else $error("rom not at both addresses");
  // RULE4 check
  probe_length_a: // RULE4
    assert property (state_reg == bil_pkg::ST_COPY_RD
      && $past(state_reg) == bil_pkg::ST_PROBE_WAIT
      |-> $past(byte_idx_reg) == 5'h1F)
    else $error("copy began before 32 bytes");
  // RULE22 check
  bad_source_dropped_a: // RULE22
    assert property (probe_fail && !last_src
      |=> src_reg == bil_pkg::bil_src_t'($past(src_reg) + 2'h1)
      && byte_idx_reg == 5'h00)
    else $error("failing source not dropped");
  // RULE12 check
  init_order_a: // RULE12
    assert property (state_reg == bil_pkg::ST_STACK |=>
      state_reg == bil_pkg::ST_OSC ##1 state_reg == bil_pkg::ST_IRQ
      ##1 state_reg == bil_pkg::ST_VARS ##1 state_reg == bil_pkg::ST_MAIN)
    else $error("init steps out of order");
  // RULE19 check
  crc_request_a: // RULE19
    assert property ($rose(state_reg == bil_pkg::ST_UP_START)
      |=> dbg_tx_valid && dbg_tx_data == 8'h43)
    else $error("upload start char missing");
  // RULE18 check
  upload_addr_a: // RULE18
    assert property (state_reg == bil_pkg::ST_UPLOAD && upload.valid
      |=> sram_wr.we && sram_wr.addr == 32'h0020_0000 + $past(up_cnt_reg))
    else $error("upload write misplaced");
  // RULE20 check
  remapped_map_a: // RULE20
    assert property (state_reg == bil_pkg::ST_RUN
      |-> sram_at_zero && !rom_at_zero && rom_at_base)
    else $error("map wrong after remap");
endmodule : bil_boot_loader

// ---- dv/bil_tb_pkg.sv ----
// Image contents shared by the memory model and the bench
package bil_tb_pkg;
  function automatic logic [7:0] img_byte(logic [16:0] a, logic [31:0] sw,
    logic bad);
    logic [31:0] w;
    case (a[4:2])
      3'h0: w = 32'hEA00000B;
      3'h5: w = sw;
      3'h6, 3'h7: w = 32'hE51FFF20;
      default: w = 32'hE59FF014;
    endcase
    if (bad && a[4:2] == 3'h7) w[31:28] = 4'hD;
    if (a > 17'h1F) w = {4{a[7:0] ^ 8'h5A}};
    return w[8 * a[1:0] +: 8];
  endfunction : img_byte
endpackage : bil_tb_pkg

// ---- dv/bil_nvm_model.sv ----
// Far-side memories: serial flash, two-wire EEPROM, parallel memory
`timescale 1ns/10ps
module bil_nvm_model (
  // Clock
  input wire logic clk,
  // Loader side
  input wire bil_pkg::bil_nvm_req_t req,
  output bil_pkg::bil_nvm_rsp_t rsp,
  // Bench control
  input wire logic [2:0] present,
  input wire logic [2:0] corrupt,
  input wire logic [31:0] size_w
);
  bil_pkg::bil_nvm_req_t held;
  int wait_n;
  initial
  begin
    rsp = '0;
    held = '0;
    wait_n = 0;
  end
  // Odd addresses answer slowly, even ones promptly
  always @(posedge clk)
  begin
    rsp.ack <= 1'b0;
    rsp.nak <= 1'b0;
    rsp.data <= ~rsp.data;
    if (req.valid)
    begin
      held <= req;
      wait_n <= req.addr[0] ? 3 : 1;
    end
    else if (wait_n > 1)
      wait_n <= wait_n - 1;
    else if (wait_n == 1)
    begin
      wait_n <= 0;
      if (present[held.src])
      begin
        rsp.ack <= 1'b1;
        rsp.data <= bil_tb_pkg::img_byte(held.addr, size_w,
          corrupt[held.src]);
      end
      else
        rsp.nak <= 1'b1;
    end
  end
endmodule : bil_nvm_model

// ---- dv/boot_image_loader_bench.sv ----
// Self-checking bench for the boot image loader
`timescale 1ns/10ps
module boot_image_loader_bench;
  logic clk, resetn, boot_sel, ext, osc_valid, tx_ready, tx_valid, pll_en;
  logic known, rom_zero, rom_base, sram_zero, br, usb_en;
  logic [31:0] osc_hz, size_w, fetch;
  logic [2:0] present, corrupt;
  logic [10:0] mul;
  logic [14:0] psize;
  logic [15:0] pcount;
  logic [7:0] tx_data;
  bil_pkg::bil_nvm_req_t req;
  bil_pkg::bil_nvm_rsp_t rsp;
  bil_pkg::bil_sram_wr_t wr;
  bil_pkg::bil_up_t upload;
  bil_pkg::bil_state_t st;
  int err_count, checked;
  int f_tab [4] = '{3000000, 18432000, 20000000, 12345678};
  int m_tab [4] = '{32, 5, 5, 0};

  bil_boot_loader dut (.clk(clk), .resetn(resetn),
    .boot_mode_select(boot_sel),
    .ext_bus_present(ext), .osc_hz(osc_hz), .osc_valid(osc_valid),
    .usb_pll_mul(mul), .usb_pll_en(pll_en), .xtal_known(known),
    .nvm_req(req), .nvm_rsp(rsp), .flash_page_size(psize),
    .flash_page_count(pcount), .sram_wr(wr), .rom_at_zero(rom_zero),
    .rom_at_base(rom_base), .sram_at_zero(sram_zero), .fetch_addr(fetch),
    .branch_pulse(br), .boot_state(st), .dbg_tx_valid(tx_valid),
    .dbg_tx_data(tx_data), .dbg_tx_ready(tx_ready), .usb_port_en(usb_en),
    .upload(upload));
  bil_nvm_model mem (.clk(clk), .req(req), .rsp(rsp), .present(present),
    .corrupt(corrupt), .size_w(size_w));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic boot(input logic b, input logic e, input logic [31:0] f);
    @(posedge clk);
    #10 resetn = 1'b0;
    boot_sel = b;
    ext = e;
    osc_hz = f;
    osc_valid = 1'b0;
    repeat (10) @(posedge clk);
    #10 resetn = 1'b1;
    osc_valid = 1'b1;
  endtask : boot

  task automatic wait_st(input bil_pkg::bil_state_t s);
    for (int i = 0; i < 200 && st !== s; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(st, s);
  endtask : wait_st

  // Next probe of a source starts at byte zero
  task automatic wait_probe(input bil_pkg::bil_src_t s);
    for (int i = 0; i < 200 && !(req.valid === 1'b1 && req.addr == 0); i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(req.src, s);
    @(posedge clk);
    #1;
  endtask : wait_probe

  task automatic wait_we();
    for (int i = 0; i < 300 && wr.we !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
  endtask : wait_we

  task automatic copy_check(input int n, input logic bad);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      #1;
      wait_we();
      chk(wr.addr, bil_pkg::SRAM_BASE + i);
      chk(wr.data, bil_tb_pkg::img_byte(17'(i), size_w, bad));
    end
  endtask : copy_check

  task automatic end_check();
    for (int i = 0; i < 20 && br !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(br, 1);
    chk({sram_zero, rom_zero, rom_base}, 3'b101);
    chk(fetch, bil_pkg::RESET_VECTOR);
  endtask : end_check

  initial
  begin
    err_count = 0;
    checked = 0;
    resetn = 1'b0;
    {boot_sel, ext, osc_valid, tx_ready} = '0;
    {osc_hz, size_w, present, corrupt} = '0;
    upload = '0;
    for (int k = 0; k < 2; k++)
    begin
      boot(k[0], !k[0], 32'h0);
      repeat (20) @(posedge clk);
      #1;
      chk(st, bil_pkg::ST_OFF);
      chk({rom_zero, rom_base, sram_zero}, 3'b110);
    end
    $display("test straps done");
    for (int k = 0; k < 4; k++)
    begin
      boot(1'b1, 1'b1, f_tab[k]);
      wait_st(bil_pkg::ST_STACK);
      for (int j = 1; j < 6; j++)
      begin
        @(posedge clk);
        #1;
        chk(st, 32'(bil_pkg::ST_STACK) + j);
      end
      chk(mul, m_tab[k]);
      chk({pll_en, known}, {2{k < 3}});
    end
    $display("test init done");
    size_w = 32'h0841A001;
    present = 3'b001;
    corrupt = 3'b000;
    boot(1'b1, 1'b1, f_tab[1]);
    wait_probe(bil_pkg::SRC_SPI);
    copy_check(512, 1'b0);
    chk(psize, 15'h0420);
    chk(pcount, 16'h2000);
    end_check();
    $display("test flash done");
    present = 3'b011;
    corrupt = 3'b001;
    boot(1'b1, 1'b1, f_tab[1]);
    wait_probe(bil_pkg::SRC_SPI);
    wait_probe(bil_pkg::SRC_EEPROM);
    copy_check(512, 1'b0);
    chk({psize, pcount}, 31'h0);
    end_check();
    $display("test eeprom done");
    present = 3'b101;
    corrupt = 3'b101;
    boot(1'b1, 1'b1, f_tab[1]);
    wait_probe(bil_pkg::SRC_SPI);
    wait_probe(bil_pkg::SRC_EEPROM);
    wait_probe(bil_pkg::SRC_PAR);
    wait_st(bil_pkg::ST_UP_START);
    repeat (3) @(posedge clk);
    #1;
    chk({tx_valid, tx_data, usb_en}, {1'b1, 8'h43, 1'b1});
    #9 tx_ready = 1'b1;
    @(posedge clk);
    #10 tx_ready = 1'b0;
    wait_st(bil_pkg::ST_UPLOAD);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      #10 upload = '{valid: 1'b1, data: 8'hC0 + 8'(k), done: 1'b0};
      @(posedge clk);
      #1;
      chk(wr.we, 1'b1);
      chk(wr.addr, bil_pkg::SRAM_BASE + k);
      chk(wr.data, 8'hC0 + 8'(k));
      #9 upload = '0;
    end
    @(posedge clk);
    #10 upload.done = 1'b1;
    @(posedge clk);
    #10 upload = '0;
    end_check();
    $display("test upload done");
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
endmodule : boot_image_loader_bench
